// ---- rtl/sdpp_pkg.sv ----
package sdpp_pkg;

    // Divider field widths
    localparam int INT_W = 6;
    localparam int FRAC_W = 12;
    localparam int DIV_W = 3;
    localparam int RATIO_W = 6;
    localparam int FB_W = INT_W + FRAC_W;

    // Serial word: MSB first, {bank B, bank A, integer, fraction}
    localparam int SWORD_W = FB_W + 2 * DIV_W;
    localparam int SW_FRAC_LSB = 0;
    localparam int SW_INT_LSB = FRAC_W;
    localparam int SW_A_LSB = FB_W;
    localparam int SW_B_LSB = FB_W + DIV_W;

    // Pin synchroniser width: seven single pins plus the buses
    localparam int SYNC_W = 7 + INT_W + 3 * DIV_W;

    // Reset values of the divider settings
    localparam logic [INT_W-1:0] INT_RST = 6'h00;
    localparam logic [FRAC_W-1:0] FRAC_RST = 12'h000;
    localparam logic [DIV_W-1:0] OUTDIV_RST = 3'h3;
    localparam logic [DIV_W-1:0] PRE_RST = 3'h0;
    localparam logic [SWORD_W-1:0] SHIFT_RST = 24'h000000;

    // Division ratios indexed by the three-bit codes
    localparam logic [RATIO_W-1:0] PRE_RATIO [8] = '{
        6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h05, 6'h19};
    localparam logic [RATIO_W-1:0] OUT_RATIO [8] = '{
        6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h08, 6'h10};

    // Register bus
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] FEEDBACK_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] OUTDIV_OFS = 8'h0C;
    localparam logic [ADDR_W-1:0] RATIO_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] SHIFT_OFS = 8'h14;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Field positions inside the registers
    localparam int CTRL_RST_BIT = 0;
    localparam int ST_NLOAD_BIT = 0;
    localparam int ST_BYPASS_BIT = 1;
    localparam int ST_REFSEL_BIT = 2;
    localparam int ST_MR_BIT = 3;
    localparam int ST_DIVRST_BIT = 4;
    localparam int ST_TEST_BIT = 5;
    localparam int FBR_FRAC_LSB = 0;
    localparam int FBR_INT_LSB = 16;
    localparam int ODR_A_LSB = 0;
    localparam int ODR_B_LSB = 4;
    localparam int ODR_PRE_LSB = 8;
    localparam int RTR_A_LSB = 0;
    localparam int RTR_B_LSB = 8;
    localparam int RTR_PRE_LSB = 16;

endpackage : sdpp_pkg

// ---- rtl/sdpp_sync.sv ----
`timescale 1ns/10ps

module sdpp_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta;

    // Two flip-flop stages per bit; only the second stage is read
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    meta[g] <= 1'b0;
                    o_sync[g] <= 1'b0;
                end else begin
                    meta[g] <= i_async[g];
                    o_sync[g] <= meta[g];
                end
            end
        end
    endgenerate

endmodule : sdpp_sync

// ---- rtl/sdpp_top.sv ----
`timescale 1ns/10ps

// Function
// - Reference select low crystal, high differential
// - Load pin governs parallel divider loading
// - Rising load pin latches integer bits
// - Fraction writable only over serial port
// - Mode pin selects PLL or bypass
// - Load low passes pins through, test low
// - Latched parallel data held until replaced
// - Serial clock rise shifts data in
// - Strobe rise copies shift register out
// - Strobe fall keeps divider values latched
// - Strobe high streams data into feedback
// - Integer bits are plain unsigned binary
// - Pre-divider code decodes to ratio
// - Output divider code decodes to ratio
// - Two independent bank divider fields
// - Master reset resets dividers, keeps values
// - Test output active serial, low parallel
module sdpp_top (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // AXI4-Lite write channels
    input wire logic [sdpp_pkg::ADDR_W-1:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [sdpp_pkg::DATA_W-1:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [sdpp_pkg::ADDR_W-1:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [sdpp_pkg::DATA_W-1:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    // Programming pins
    input wire logic i_parallel_load_n,
    input wire logic [sdpp_pkg::INT_W-1:0] i_feedback_int_bits,
    input wire logic [sdpp_pkg::DIV_W-1:0] i_bank_a_divider_bits,
    input wire logic [sdpp_pkg::DIV_W-1:0] i_bank_b_divider_bits,
    input wire logic [sdpp_pkg::DIV_W-1:0] i_pre_divider_bits,
    input wire logic i_serial_clock,
    input wire logic i_serial_data,
    input wire logic i_transfer_strobe,
    // Mode and reset pins
    input wire logic i_master_reset_pin,
    input wire logic i_ref_select,
    input wire logic i_pll_bypass_select,
    // Divider settings to the synthesizer core
    output logic [sdpp_pkg::INT_W-1:0] o_feedback_int,
    output logic [sdpp_pkg::FRAC_W-1:0] o_feedback_frac,
    output logic [sdpp_pkg::DIV_W-1:0] o_bank_a_div,
    output logic [sdpp_pkg::DIV_W-1:0] o_bank_b_div,
    output logic [sdpp_pkg::DIV_W-1:0] o_pre_div,
    output logic [sdpp_pkg::RATIO_W-1:0] o_bank_a_ratio,
    output logic [sdpp_pkg::RATIO_W-1:0] o_bank_b_ratio,
    output logic [sdpp_pkg::RATIO_W-1:0] o_pre_ratio,
    // Core control
    output logic o_ref_diff_select,
    output logic o_bypass_mode,
    output logic o_divider_reset,
    output logic o_test
);

    logic [sdpp_pkg::SYNC_W-1:0] sync_in;
    logic [sdpp_pkg::SYNC_W-1:0] sync_out;
    logic sclk_s, sdata_s, strobe_s, nload_s, mr_s, sel_s, byp_s;
    logic [sdpp_pkg::INT_W-1:0] int_s;
    logic [sdpp_pkg::DIV_W-1:0] a_s, b_s, pre_s;
    logic sclk_q, strobe_q, nload_q;
    logic sclk_rise, strobe_rise, strobe_fall, nload_rise;

    // Every pin passes two flip-flops before use
    assign sync_in = {i_serial_clock, i_serial_data, i_transfer_strobe,
        i_parallel_load_n, i_master_reset_pin, i_ref_select,
        i_pll_bypass_select, i_feedback_int_bits, i_bank_a_divider_bits,
        i_bank_b_divider_bits, i_pre_divider_bits};

    sdpp_sync #(.WIDTH(sdpp_pkg::SYNC_W)) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_async(sync_in),
        .o_sync(sync_out)
    );

    assign {sclk_s, sdata_s, strobe_s, nload_s, mr_s, sel_s, byp_s,
        int_s, a_s, b_s, pre_s} = sync_out;

    // Edge detection on the synchronised strobes
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sclk_q <= 1'b0;
            strobe_q <= 1'b0;
            nload_q <= 1'b0;
        end else begin
            sclk_q <= sclk_s;
            strobe_q <= strobe_s;
            nload_q <= nload_s;
        end
    end

    assign sclk_rise = sclk_s && !sclk_q;
    assign strobe_rise = strobe_s && !strobe_q;
    assign strobe_fall = !strobe_s && strobe_q;
    assign nload_rise = nload_s && !nload_q;

    // Programming state
    logic [sdpp_pkg::SWORD_W-1:0] shift, next_shift;
    logic [sdpp_pkg::INT_W-1:0] par_int, next_par_int, next_int;
    logic [sdpp_pkg::DIV_W-1:0] par_a, par_b, par_pre;
    logic [sdpp_pkg::DIV_W-1:0] next_par_a, next_par_b, next_par_pre;
    logic [sdpp_pkg::FRAC_W-1:0] next_frac;
    logic [sdpp_pkg::DIV_W-1:0] next_a, next_b, next_pre;
    logic next_test;
    logic ctrl_rst;

    // Parallel pass-through, latching, serial shift and transfer
    always_comb begin
        logic [sdpp_pkg::FB_W-1:0] fb_word;
        fb_word = {o_feedback_int, o_feedback_frac};
        next_shift = shift;
        next_par_int = par_int;
        next_par_a = par_a;
        next_par_b = par_b;
        next_par_pre = par_pre;
        next_int = o_feedback_int;
        next_frac = o_feedback_frac;
        next_a = o_bank_a_div;
        next_b = o_bank_b_div;
        next_pre = o_pre_div;
        // Serial mode shows the shift register output on test
        next_test = nload_s ? shift[sdpp_pkg::SWORD_W-1] : 1'b0;
        // Master reset leaves every loaded value untouched
        if (!mr_s) begin
            if (!nload_s) begin
                // Pins drive the dividers directly; fraction is kept
                next_int = int_s;
                next_a = a_s;
                next_b = b_s;
                next_pre = pre_s;
            end else begin
                if (nload_rise) begin
                    next_par_int = int_s;
                    next_par_a = a_s;
                    next_par_b = b_s;
                    next_par_pre = pre_s;
                    next_int = int_s;
                    next_a = a_s;
                    next_b = b_s;
                    next_pre = pre_s;
                end
                if (!strobe_s && sclk_rise) begin
                    next_shift = {shift[sdpp_pkg::SWORD_W-2:0], sdata_s};
                end
                if (strobe_rise && !sclk_s) begin
                    // Shift word replaces the held parallel values except the pre-divider
                    next_frac = shift[sdpp_pkg::SW_FRAC_LSB +: sdpp_pkg::FRAC_W];
                    next_int = shift[sdpp_pkg::SW_INT_LSB +: sdpp_pkg::INT_W];
                    next_a = shift[sdpp_pkg::SW_A_LSB +: sdpp_pkg::DIV_W];
                    next_b = shift[sdpp_pkg::SW_B_LSB +: sdpp_pkg::DIV_W];
                end else if (strobe_fall && !sclk_s) begin
                    next_int = o_feedback_int;
                    next_a = o_bank_a_div;
                end
                if (strobe_s && sclk_rise) begin
                    // Each bit enters the feedback divider directly
                    fb_word = {fb_word[sdpp_pkg::FB_W-2:0], sdata_s};
                    next_int = fb_word[sdpp_pkg::FRAC_W +: sdpp_pkg::INT_W];
                    next_frac = fb_word[sdpp_pkg::FRAC_W-1:0];
                end
            end
        end
    end

    // Register the programming state and the decoded outputs
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shift <= sdpp_pkg::SHIFT_RST;
            par_int <= sdpp_pkg::INT_RST;
            par_a <= sdpp_pkg::OUTDIV_RST;
            par_b <= sdpp_pkg::OUTDIV_RST;
            par_pre <= sdpp_pkg::PRE_RST;
            o_feedback_int <= sdpp_pkg::INT_RST;
            o_feedback_frac <= sdpp_pkg::FRAC_RST;
            o_bank_a_div <= sdpp_pkg::OUTDIV_RST;
            o_bank_b_div <= sdpp_pkg::OUTDIV_RST;
            o_pre_div <= sdpp_pkg::PRE_RST;
            o_bank_a_ratio <= sdpp_pkg::OUT_RATIO[sdpp_pkg::OUTDIV_RST];
            o_bank_b_ratio <= sdpp_pkg::OUT_RATIO[sdpp_pkg::OUTDIV_RST];
            o_pre_ratio <= sdpp_pkg::PRE_RATIO[sdpp_pkg::PRE_RST];
            o_test <= 1'b0;
            o_ref_diff_select <= 1'b0;
            o_bypass_mode <= 1'b0;
            o_divider_reset <= 1'b0;
        end else begin
            shift <= next_shift;
            par_int <= next_par_int;
            par_a <= next_par_a;
            par_b <= next_par_b;
            par_pre <= next_par_pre;
            o_feedback_int <= next_int;
            o_feedback_frac <= next_frac;
            o_bank_a_div <= next_a;
            o_bank_b_div <= next_b;
            o_pre_div <= next_pre;
            o_bank_a_ratio <= sdpp_pkg::OUT_RATIO[next_a];
            o_bank_b_ratio <= sdpp_pkg::OUT_RATIO[next_b];
            o_pre_ratio <= sdpp_pkg::PRE_RATIO[next_pre];
            o_test <= next_test;
            o_ref_diff_select <= sel_s;
            o_bypass_mode <= byp_s;
            o_divider_reset <= mr_s || ctrl_rst;
        end
    end

    // Register bus state
    logic aw_have, next_aw_have, w_have, next_w_have;
    logic [sdpp_pkg::ADDR_W-1:0] aw_addr, next_aw_addr;
    logic [sdpp_pkg::DATA_W-1:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [sdpp_pkg::DATA_W-1:0] next_rdata;
    logic next_ctrl_rst;

    // Write and read channel handling, one of each at a time
    always_comb begin
        logic [sdpp_pkg::DATA_W-1:0] rd;
        rd = '0;
        next_aw_have = aw_have;
        next_aw_addr = aw_addr;
        next_w_have = w_have;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = o_s_axi_bvalid;
        next_bresp = o_s_axi_bresp;
        next_ctrl_rst = ctrl_rst;
        next_rvalid = o_s_axi_rvalid;
        next_rdata = o_s_axi_rdata;
        next_rresp = o_s_axi_rresp;
        if (i_s_axi_awvalid && o_s_axi_awready) begin
            next_aw_have = 1'b1;
            next_aw_addr = i_s_axi_awaddr;
        end
        if (i_s_axi_wvalid && o_s_axi_wready) begin
            next_w_have = 1'b1;
            next_w_data = i_s_axi_wdata;
            next_w_strb = i_s_axi_wstrb;
        end
        if (o_s_axi_bvalid && i_s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (aw_have && w_have && !o_s_axi_bvalid) begin
            next_aw_have = 1'b0;
            next_w_have = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = sdpp_pkg::RESP_OKAY;
            if (aw_addr == sdpp_pkg::CTRL_OFS) begin
                if (w_strb[0]) begin
                    next_ctrl_rst = w_data[sdpp_pkg::CTRL_RST_BIT];
                end
            end else if (aw_addr == sdpp_pkg::STATUS_OFS ||
                         aw_addr == sdpp_pkg::FEEDBACK_OFS ||
                         aw_addr == sdpp_pkg::OUTDIV_OFS ||
                         aw_addr == sdpp_pkg::RATIO_OFS ||
                         aw_addr == sdpp_pkg::SHIFT_OFS) begin
                next_bresp = sdpp_pkg::RESP_OKAY;
            end else begin
                next_bresp = sdpp_pkg::RESP_SLVERR;
            end
        end
        next_awready = !next_aw_have && !next_bvalid;
        next_wready = !next_w_have && !next_bvalid;
        if (o_s_axi_rvalid && i_s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (i_s_axi_arvalid && o_s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = sdpp_pkg::RESP_OKAY;
            if (i_s_axi_araddr == sdpp_pkg::CTRL_OFS) begin
                rd[sdpp_pkg::CTRL_RST_BIT] = ctrl_rst;
            end else if (i_s_axi_araddr == sdpp_pkg::STATUS_OFS) begin
                rd[sdpp_pkg::ST_NLOAD_BIT] = nload_s;
                rd[sdpp_pkg::ST_BYPASS_BIT] = o_bypass_mode;
                rd[sdpp_pkg::ST_REFSEL_BIT] = o_ref_diff_select;
                rd[sdpp_pkg::ST_MR_BIT] = mr_s;
                rd[sdpp_pkg::ST_DIVRST_BIT] = o_divider_reset;
                rd[sdpp_pkg::ST_TEST_BIT] = o_test;
            end else if (i_s_axi_araddr == sdpp_pkg::FEEDBACK_OFS) begin
                rd[sdpp_pkg::FBR_FRAC_LSB +: sdpp_pkg::FRAC_W] = o_feedback_frac;
                rd[sdpp_pkg::FBR_INT_LSB +: sdpp_pkg::INT_W] = o_feedback_int;
            end else if (i_s_axi_araddr == sdpp_pkg::OUTDIV_OFS) begin
                rd[sdpp_pkg::ODR_A_LSB +: sdpp_pkg::DIV_W] = o_bank_a_div;
                rd[sdpp_pkg::ODR_B_LSB +: sdpp_pkg::DIV_W] = o_bank_b_div;
                rd[sdpp_pkg::ODR_PRE_LSB +: sdpp_pkg::DIV_W] = o_pre_div;
            end else if (i_s_axi_araddr == sdpp_pkg::RATIO_OFS) begin
                rd[sdpp_pkg::RTR_A_LSB +: sdpp_pkg::RATIO_W] = o_bank_a_ratio;
                rd[sdpp_pkg::RTR_B_LSB +: sdpp_pkg::RATIO_W] = o_bank_b_ratio;
                rd[sdpp_pkg::RTR_PRE_LSB +: sdpp_pkg::RATIO_W] = o_pre_ratio;
            end else if (i_s_axi_araddr == sdpp_pkg::SHIFT_OFS) begin
                rd[sdpp_pkg::SWORD_W-1:0] = shift;
            end else begin
                next_rresp = sdpp_pkg::RESP_SLVERR;
            end
            next_rdata = rd;
        end
        next_arready = !next_rvalid;
    end

    // Register bus flip-flops
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_have <= 1'b0;
            aw_addr <= '0;
            w_have <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
            ctrl_rst <= 1'b0;
            o_s_axi_awready <= 1'b0;
            o_s_axi_wready <= 1'b0;
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp <= sdpp_pkg::RESP_OKAY;
            o_s_axi_arready <= 1'b0;
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata <= '0;
            o_s_axi_rresp <= sdpp_pkg::RESP_OKAY;
        end else begin
            aw_have <= next_aw_have;
            aw_addr <= next_aw_addr;
            w_have <= next_w_have;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            ctrl_rst <= next_ctrl_rst;
            o_s_axi_awready <= next_awready;
            o_s_axi_wready <= next_wready;
            o_s_axi_bvalid <= next_bvalid;
            o_s_axi_bresp <= next_bresp;
            o_s_axi_arready <= next_arready;
            o_s_axi_rvalid <= next_rvalid;
            o_s_axi_rdata <= next_rdata;
            o_s_axi_rresp <= next_rresp;
        end
    end

    // Checks on the programming behaviour
    property p_pass_through;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (!nload_s && !mr_s) |=> (o_feedback_int == $past(int_s)
            && o_bank_b_div == $past(b_s));
    endproperty
    a_pass_through: assert property (p_pass_through)
        else $error("pins not passed through in parallel mode");

    property p_test_low;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        !nload_s [*2] |-> !o_test;
    endproperty
    a_test_low: assert property (p_test_low)
        else $error("test output not low in parallel mode");

    property p_shift;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (nload_s && !mr_s && !strobe_s && sclk_rise) |=>
            (shift[0] == $past(sdata_s) && shift[1] == $past(shift[0]));
    endproperty
    a_shift: assert property (p_shift)
        else $error("serial bit not shifted in");

    property p_transfer;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (nload_s && !mr_s && strobe_rise && !sclk_s) |=>
            (o_bank_a_div == $past(shift[sdpp_pkg::SW_A_LSB +: sdpp_pkg::DIV_W])
            && o_feedback_frac == $past(shift[sdpp_pkg::FRAC_W-1:0]));
    endproperty
    a_transfer: assert property (p_transfer)
        else $error("shift word not transferred on strobe rise");

    property p_reset_keeps;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        mr_s |=> ($stable(o_feedback_int) && $stable(o_bank_a_div)
            && o_divider_reset);
    endproperty
    a_reset_keeps: assert property (p_reset_keeps)
        else $error("master reset disturbed loaded values");

    property p_ratio;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        o_pre_ratio == sdpp_pkg::PRE_RATIO[o_pre_div]
            && o_bank_a_ratio == sdpp_pkg::OUT_RATIO[o_bank_a_div];
    endproperty
    a_ratio: assert property (p_ratio)
        else $error("decoded ratio does not match code");

    property p_stream;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (nload_s && !mr_s && strobe_s && sclk_rise) |=>
            (o_feedback_frac[0] == $past(sdata_s));
    endproperty
    a_stream: assert property (p_stream)
        else $error("streamed bit missing from feedback divider");

    property p_hold;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (nload_s && !nload_rise && !strobe_rise && !sclk_rise) |=>
            $stable(o_bank_b_div) ##1 (!nload_s || $stable(o_pre_div));
    endproperty
    a_hold: assert property (p_hold)
        else $error("held parallel data changed");

    property p_latch;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (nload_rise && !mr_s && !strobe_rise && !(strobe_s && sclk_rise))
            |=> (par_int == $past(int_s) && o_feedback_int == par_int);
    endproperty
    a_latch: assert property (p_latch)
        else $error("integer bits not latched on load rise");

    property p_mode;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        ##1 (o_bypass_mode == $past(byp_s)
            && o_ref_diff_select == $past(sel_s));
    endproperty
    a_mode: assert property (p_mode)
        else $error("mode or reference select not followed");

endmodule : sdpp_top

// ---- test/sdpp_cfg_model.sv ----
`timescale 1ns/10ps

// Configuration controller driving the serial programming pins
module sdpp_cfg_model (
    // Clock
    input wire logic i_sys_clk,
    // Serial pins
    output logic o_serial_clock = 1'b0,
    output logic o_serial_data = 1'b0,
    output logic o_transfer_strobe = 1'b0
);
    // One bit: data set, clock high and low four cycles each
    task send_bit(input logic b);
        o_serial_data <= b;
        repeat (4) @(posedge i_sys_clk);
        o_serial_clock <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        o_serial_clock <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
    endtask : send_bit
    // Whole word MSB first; data line is driven low after
    task send_word(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) send_bit(w[i]);
        o_serial_data <= 1'b0;
    endtask : send_word
    // Strobe change, always with the serial clock low
    task set_strobe(input logic v);
        o_transfer_strobe <= v;
        repeat (6) @(posedge i_sys_clk);
    endtask : set_strobe
endmodule : sdpp_cfg_model

// ---- test/sdpp_top_tb_top.sv ----
`timescale 1ns/10ps

module sdpp_top_tb_top;
    logic i_sys_clk = 0, i_rst_n = 0, i_s_axi_awvalid = 0, i_s_axi_wvalid = 0;
    logic i_s_axi_bready = 0, i_s_axi_arvalid = 0, i_s_axi_rready = 0;
    logic [7:0] i_s_axi_awaddr = 0, i_s_axi_araddr = 0;
    logic [31:0] i_s_axi_wdata = 0, o_s_axi_rdata, rd_d;
    logic [3:0] i_s_axi_wstrb = 4'hF;
    logic [1:0] o_s_axi_bresp, o_s_axi_rresp, rd_r;
    logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
    logic o_s_axi_rvalid, i_parallel_load_n = 0, i_master_reset_pin = 0;
    logic i_ref_select = 0, i_pll_bypass_select = 0, o_ref_diff_select;
    logic [5:0] i_feedback_int_bits = 0, o_feedback_int;
    logic [2:0] i_bank_a_divider_bits = 0, i_bank_b_divider_bits = 0;
    logic [2:0] i_pre_divider_bits = 0, o_bank_a_div, o_bank_b_div, o_pre_div;
    logic [5:0] o_bank_a_ratio, o_bank_b_ratio, o_pre_ratio;
    logic [11:0] o_feedback_frac;
    logic [17:0] fb_exp;
    logic i_serial_clock, i_serial_data, i_transfer_strobe;
    logic o_bypass_mode, o_divider_reset, o_test;
    int bad_count = 0, samples_checked = 0, cyc = 0;
    localparam logic [5:0] PRT [8] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10,
        6'h20, 6'h05, 6'h19};
    localparam logic [5:0] ORT [8] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05,
        6'h06, 6'h08, 6'h10};
    sdpp_top i_sdpp_top (.i_sys_clk, .i_rst_n, .i_s_axi_awaddr,
        .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb,
        .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid,
        .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready,
        .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready,
        .i_parallel_load_n, .i_feedback_int_bits, .i_bank_a_divider_bits,
        .i_bank_b_divider_bits, .i_pre_divider_bits, .i_serial_clock,
        .i_serial_data, .i_transfer_strobe, .i_master_reset_pin, .i_ref_select,
        .i_pll_bypass_select, .o_feedback_int, .o_feedback_frac, .o_bank_a_div,
        .o_bank_b_div, .o_pre_div, .o_bank_a_ratio, .o_bank_b_ratio,
        .o_pre_ratio, .o_ref_diff_select, .o_bypass_mode, .o_divider_reset,
        .o_test);
    sdpp_cfg_model i_sdpp_cfg_model (.i_sys_clk, .o_serial_clock(i_serial_clock),
        .o_serial_data(i_serial_data), .o_transfer_strobe(i_transfer_strobe));
    // Clock and hang guard
    initial forever #12.5 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            end_sim();
        end
    end
    task automatic w(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask : w
    task chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            bad_count++;
            $display("FAIL t=%0t seen %h exp %h", $time, s, e);
        end
    endtask : chk
    // Register write: address and data offered together, each released alone
    task wr(input logic [7:0] a, input logic [31:0] d);
        i_s_axi_awaddr <= a;
        i_s_axi_wdata <= d;
        i_s_axi_awvalid <= 1;
        i_s_axi_wvalid <= 1;
        i_s_axi_bready <= 1;
        fork
            begin do w(1); while (o_s_axi_awready !== 1); i_s_axi_awvalid <= 0; end
            begin do w(1); while (o_s_axi_wready !== 1); i_s_axi_wvalid <= 0; end
        join
        while (o_s_axi_bvalid !== 1) w(1);
        rd_r = o_s_axi_bresp;
        i_s_axi_bready <= 0;
        w(1);
    endtask : wr
    // Register read
    task rd(input logic [7:0] a);
        i_s_axi_araddr <= a;
        i_s_axi_arvalid <= 1;
        i_s_axi_rready <= 1;
        do w(1); while (o_s_axi_arready !== 1);
        i_s_axi_arvalid <= 0;
        while (o_s_axi_rvalid !== 1) w(1);
        rd_d = o_s_axi_rdata;
        rd_r = o_s_axi_rresp;
        i_s_axi_rready <= 0;
        w(1);
    endtask : rd
    // Parallel pass-through over every code, both banks apart
    task t_par;
        for (int c = 0; c < 8; c++) begin
            i_bank_a_divider_bits <= 3'(c);
            i_bank_b_divider_bits <= 3'(7 - c);
            i_pre_divider_bits <= 3'(c);
            i_feedback_int_bits <= 6'(c * 9);
            i_ref_select <= c[0];
            i_pll_bypass_select <= c[1];
            w(6);
            chk(o_bank_a_ratio, ORT[c]);
            chk(o_bank_b_ratio, ORT[7-c]);
            chk(o_pre_ratio, PRT[c]);
            chk(o_feedback_int, c * 9);
            chk(o_ref_diff_select, c[0]);
            chk(o_bypass_mode, c[1]);
            chk(o_test, 0);
        end
        $display("test par done");
    endtask : t_par
    // Load rise latches, later pin changes are ignored
    task t_latch;
        i_feedback_int_bits <= 6'h2A;
        i_bank_a_divider_bits <= 3'h1;
        w(6);
        i_parallel_load_n <= 1;
        w(6);
        i_feedback_int_bits <= 6'h15;
        i_bank_a_divider_bits <= 3'h6;
        w(6);
        chk(o_feedback_int, 6'h2A);
        chk(o_bank_a_div, 3'h1);
        $display("test latch done");
    endtask : t_latch
    // Serial word, transfer, stream one bit, strobe fall, master reset
    task t_ser;
        i_sdpp_cfg_model.send_word(24'hAB1ABC);
        chk(o_test, 1);
        i_sdpp_cfg_model.set_strobe(1);
        chk({o_bank_b_div, o_bank_a_div}, 6'h2A);
        chk({o_feedback_int, o_feedback_frac}, 18'h31ABC);
        fb_exp = 18'h23579;
        i_sdpp_cfg_model.send_bit(1);
        w(6);
        chk({o_feedback_int, o_feedback_frac}, fb_exp);
        i_sdpp_cfg_model.set_strobe(0);
        i_master_reset_pin <= 1;
        w(6);
        chk(o_divider_reset, 1);
        chk({o_feedback_int, o_feedback_frac}, fb_exp);
        i_master_reset_pin <= 0;
        w(6);
        $display("test serial done");
    endtask : t_ser
    // Register map: readback, unmapped read, soft divider reset
    task t_axi;
        rd(sdpp_pkg::FEEDBACK_OFS);
        chk(rd_d, {10'h0, fb_exp[17:12], 4'h0, fb_exp[11:0]});
        rd(sdpp_pkg::SHIFT_OFS);
        chk(rd_d, 24'hAB1ABC);
        rd(8'h40);
        chk(rd_r, sdpp_pkg::RESP_SLVERR);
        chk(rd_d, 0);
        wr(sdpp_pkg::CTRL_OFS, 32'h1);
        chk(rd_r, sdpp_pkg::RESP_OKAY);
        w(2);
        chk(o_divider_reset, 1);
        wr(sdpp_pkg::CTRL_OFS, 32'h0);
        $display("test axi done");
    endtask : t_axi
    task end_sim;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    initial begin
        w(20);
        i_rst_n <= 1;
        w(8);
        t_par();
        t_latch();
        t_ser();
        t_axi();
        end_sim();
    end
endmodule : sdpp_top_tb_top
